// [hw/dbap_pkg.sv]
// How it works
// - Host writes an address register that targets the next system bus transfer.
// - Any host read or write of the data window starts one bus transfer.
// - Low two bus address bits come straight from the address register.
// - Bus transfer size comes from the size field of the control word.
// - No realignment; unaligned addresses go to the bus unchanged.
package dbap_pkg;
   // ----------------------------------------
   // Host register selects
   // ----------------------------------------
   localparam logic [1:0] SEL_ADDRESS = 2'h0;
   localparam logic [1:0] SEL_CONTROL = 2'h1;
   localparam logic [1:0] SEL_WINDOW  = 2'h2;

   // ----------------------------------------
   // Bus encodings and reset values
   // ----------------------------------------
   localparam logic [2:0] SIZE_BYTE   = 3'h0;
   localparam logic [2:0] SIZE_HALF   = 3'h1;
   localparam logic [2:0] SIZE_WORD   = 3'h2;
   localparam logic [1:0] TRANS_IDLE  = 2'h0;
   localparam logic [1:0] TRANS_NSEQ  = 2'h2;
   localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
   localparam logic [31:0] DATA_RESET = 32'h0000_0000;
   localparam logic [2:0] SIZE_RESET  = 3'h2;
   localparam int SIZE_LSB            = 0;
   localparam int SIZE_MSB            = 2;

   typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA} dbap_state_type;
endpackage

// [hw/dbap_port.sv]
`timescale 1ns/10ps
module dbap_port
   import dbap_pkg::*;
(
   input  wire logic        clk_sys,     // System bus clock
   input  wire logic        rst,         // Async reset, active high
   input  wire logic        hostReq,     // Host access strobe
   input  wire logic        hostWrite,   // Host access is a write
   input  wire logic [1:0]  hostSel,     // Host register select
   input  wire logic [31:0] hostWdata,   // Host write data
   output logic             hostBusy,    // Port busy, requests ignored
   output logic             hostDone,    // Access complete pulse
   output logic [31:0]      hostRdata,   // Host read data
   output logic [31:0]      haddr,       // Bus address
   output logic [1:0]       htrans,      // Bus transfer type
   output logic             hwrite,      // Bus write
   output logic [2:0]       hsize,       // Bus size
   output logic [31:0]      hwdata,      // Bus write data
   input  wire logic        hready,      // Bus ready
   input  wire logic [31:0] hrdata,      // Bus read data
   input  wire logic        hresp        // Bus error response
);
   // ----------------------------------------
   // Registers and decode
   // ----------------------------------------
   logic [31:0]    accessAddress;
   logic [2:0]     accessSize;
   logic           accessError;
   logic           pendWrite;
   dbap_state_type state;

   wire takeReq     = hostReq && !hostBusy;
   wire selAddr     = takeReq && (hostSel == SEL_ADDRESS);
   wire selCtrl     = takeReq && (hostSel == SEL_CONTROL);
   wire selWindow   = takeReq && (hostSel == SEL_WINDOW);
   wire [31:0] ctrlWord = {28'h000_0000, accessError, accessSize};

   // Readback of the host-visible registers
   wire [31:0] regReadData = (hostSel == SEL_ADDRESS) ? accessAddress :
                             (hostSel == SEL_CONTROL) ? ctrlWord : DATA_RESET;

   // Address register, host written
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) accessAddress <= ADDR_RESET;
      else if (selAddr && hostWrite) accessAddress <= hostWdata;
   end

   // Control word size field, error sticky until host control write
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         accessSize  <= SIZE_RESET;
         accessError <= 1'b0;
      end else begin
         if (selCtrl && hostWrite) accessSize <= hostWdata[SIZE_MSB:SIZE_LSB];
         if (state == ST_DATA && hready && hresp) accessError <= 1'b1;
         else if (selCtrl && hostWrite) accessError <= 1'b0;
      end
   end

   // ----------------------------------------
   // Transfer sequencer
   // ----------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state     <= ST_IDLE;
         pendWrite <= 1'b0;
         haddr     <= ADDR_RESET;
         htrans    <= TRANS_IDLE;
         hwrite    <= 1'b0;
         hsize     <= SIZE_RESET;
         hwdata    <= DATA_RESET;
         hostBusy  <= 1'b0;
         hostDone  <= 1'b0;
         hostRdata <= DATA_RESET;
      end else begin
         hostDone <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (selWindow) begin
                  // Address passed unaltered, any size
                  haddr     <= accessAddress;
                  hsize     <= accessSize;
                  hwrite    <= hostWrite;
                  htrans    <= TRANS_NSEQ;
                  pendWrite <= hostWrite;
                  if (hostWrite) hwdata <= hostWdata;
                  hostBusy  <= 1'b1;
                  state     <= ST_ADDR;
               end else if (takeReq) begin
                  hostRdata <= regReadData;
                  hostDone  <= 1'b1;
               end
            end
            ST_ADDR: begin
               if (hready) begin
                  htrans <= TRANS_IDLE;
                  state  <= ST_DATA;
               end
            end
            ST_DATA: begin
               if (hready) begin
                  if (!pendWrite) hostRdata <= hrdata;
                  hostDone <= 1'b1;
                  hostBusy <= 1'b0;
                  state    <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   // Window access opens a nonsequential transfer
   a_window_starts: assert property (
      @(posedge clk_sys) disable iff (rst)
      (selWindow && state == ST_IDLE) |=> (htrans == TRANS_NSEQ))
      else
         $error("window access did not start a transfer");

   // Low bus address bits follow the address register
   a_low_bits: assert property (
      @(posedge clk_sys) disable iff (rst)
      (selWindow && state == ST_IDLE) |=> (haddr[1:0] == $past(accessAddress[1:0])))
      else
         $error("low address bits not from address register");

   // Bus size follows the control word size field
   a_size_field: assert property (
      @(posedge clk_sys) disable iff (rst)
      (htrans == TRANS_NSEQ) |-> (hsize == accessSize))
      else
         $error("bus size differs from control word");

   // Whole address goes out untouched, aligned or not
   a_no_realign: assert property (
      @(posedge clk_sys) disable iff (rst)
      (selWindow && state == ST_IDLE) |=> (haddr == $past(accessAddress)))
      else
         $error("address was realigned");

   // Host write lands in the address register
   a_addr_write: assert property (
      @(posedge clk_sys) disable iff (rst)
      (selAddr && hostWrite) |=> (accessAddress == $past(hostWdata)))
      else
         $error("address register not loaded");

   // Byte transfers start whatever the low address bits
   a_byte_any: assert property (
      @(posedge clk_sys) disable iff (rst)
      (selWindow && state == ST_IDLE && accessSize == SIZE_BYTE)
      |=> (htrans == TRANS_NSEQ && hsize == SIZE_BYTE))
      else
         $error("byte transfer refused");

   // Data phase end releases the host
   a_done_end: assert property (
      @(posedge clk_sys) disable iff (rst)
      (state == ST_DATA && hready) |=> (hostDone && !hostBusy))
      else
         $error("transfer did not complete");

   // Busy covers the whole address phase
   a_busy_hold: assert property (
      @(posedge clk_sys) disable iff (rst)
      (htrans == TRANS_NSEQ) |-> hostBusy)
      else
         $error("busy low during transfer");

   // Address phase held steady through wait states
   a_addr_hold: assert property (
      @(posedge clk_sys) disable iff (rst)
      (state == ST_ADDR && !hready)
      |=> (htrans == TRANS_NSEQ && $stable(haddr) && $stable(hsize) && $stable(hwrite)))
      else
         $error("address phase changed during wait state");

   // Window write data reaches the bus
   a_write_data: assert property (
      @(posedge clk_sys) disable iff (rst)
      (selWindow && hostWrite) |=> (hwdata == $past(hostWdata)))
      else
         $error("bus write data not from host");

   // Register access answers in the next cycle
   a_reg_answer: assert property (
      @(posedge clk_sys) disable iff (rst)
      (takeReq && !selWindow) |=> hostDone)
      else
         $error("register access not answered");

   // Data phase drives no new transfer and keeps busy
   a_data_idle: assert property (
      @(posedge clk_sys) disable iff (rst)
      (state == ST_DATA) |-> (htrans == TRANS_IDLE && hostBusy))
      else
         $error("data phase drove a new transfer");

   // Idle port issues nothing and accepts requests
   a_idle_quiet: assert property (
      @(posedge clk_sys) disable iff (rst)
      (state == ST_IDLE) |-> (htrans == TRANS_IDLE && !hostBusy))
      else
         $error("idle port busy or transferring");

   // Error response sets the sticky error bit
   a_error_sticky: assert property (
      @(posedge clk_sys) disable iff (rst)
      (state == ST_DATA && hready && hresp) |=> accessError)
      else
         $error("error response not recorded");

   // ----------------------------------------
   // Coverage of main scenarios
   // ----------------------------------------
   // Window write to completion
   c_write_xfer: cover property (@(posedge clk_sys) disable iff (rst)
      selWindow && hostWrite ##[1:20] hostDone);

   // Window read to completion
   c_read_xfer: cover property (@(posedge clk_sys) disable iff (rst)
      selWindow && !hostWrite ##[1:20] hostDone);

   // Unaligned word address on the bus
   c_unaligned: cover property (@(posedge clk_sys) disable iff (rst)
      htrans == TRANS_NSEQ && hsize == SIZE_WORD && haddr[1:0] != 2'h0);

   // Address phase stretched by a wait state
   c_wait_state: cover property (@(posedge clk_sys) disable iff (rst)
      state == ST_ADDR && !hready);

   // Error response in a data phase
   c_error_resp: cover property (@(posedge clk_sys) disable iff (rst)
      state == ST_DATA && hready && hresp);
endmodule // dbap_port

// [dv/dbap_bus_model.sv]
`timescale 1ns/10ps
module dbap_bus_model
   import dbap_pkg::*;
(
   input  wire logic        clk_sys, // Bus clock
   input  wire logic        rst,     // Async reset
   input  wire logic        stall,   // Insert wait states
   input  wire logic [1:0]  htrans,  // Transfer type
   input  wire logic [31:0] haddr,   // Bus address
   input  wire logic        fail,    // Answer with error response
   output logic             hready,  // Ready
   output logic [31:0]      hrdata,  // Read data
   output logic             hresp    // Error response
);
   logic [31:0] dAddr; // Data phase address
   logic [31:0] noise; // Changes every cycle
   logic        inData;
   // Track phases, answer reads with inverted address
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         inData <= 1'b0;
         dAddr  <= 32'h0000_0000;
         noise  <= 32'h0000_0000;
      end else begin
         noise <= noise + 32'h0101_0101;
         if (hready) inData <= (htrans == TRANS_NSEQ);
         if (hready) dAddr <= haddr;
      end
   end
   assign hready = !stall;
   assign hrdata = (inData && hready) ? ~dAddr : noise;
   assign hresp  = inData && hready && fail;
endmodule // dbap_bus_model

// [dv/dbap_port_bench.sv]
`timescale 1ns/10ps
module dbap_port_bench;
   import dbap_pkg::*;
   logic clk_sys = 0, rst = 1, hostReq = 0, hostWrite = 0, stall = 0, curWr = 0, curFail = 0;
   logic [1:0]  hostSel = 0, htrans;
   logic [31:0] hostWdata = 0, hostRdata, haddr, hwdata, hrdata, curAddr = 0;
   logic [31:0] lf = 32'h5125_332f, sr = 32'h5125_332f;
   logic [2:0]  hsize, curSize = 0;
   logic        hostBusy, hostDone, hwrite, hready, hresp;
   logic [32:0] expQ[$];
   logic [32:0] e;
   int error_cnt = 0, n_tests = 0;
   dbap_port u_dbap_port(.clk_sys(clk_sys), .rst(rst), .hostReq(hostReq), .hostWrite(hostWrite),
      .hostSel(hostSel), .hostWdata(hostWdata), .hostBusy(hostBusy), .hostDone(hostDone),
      .hostRdata(hostRdata), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hresp(hresp));
   dbap_bus_model u_dbap_bus_model(.clk_sys(clk_sys), .rst(rst), .stall(stall), .htrans(htrans),
      .haddr(haddr), .fail(curFail), .hready(hready), .hrdata(hrdata), .hresp(hresp));
   function automatic logic [31:0] nxt(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      n_tests++;
      if (g !== x) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", n, x, g);
      end
   endtask
   // One host access, expected answer noted first
   task automatic acc(input logic [1:0] s, input logic w, input logic [31:0] d, input logic [32:0] x);
      expQ.push_back(x);
      @(negedge clk_sys);
      hostSel = s;
      hostWrite = w;
      hostWdata = d;
      hostReq = 1'b1;
      @(negedge clk_sys);
      hostReq = 1'b0;
      repeat (40) if (hostDone !== 1'b1) @(negedge clk_sys);
      chk("hostDone", 32'h1, {31'h0, hostDone});
   endtask
   task automatic report_and_stop;
      $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial forever #50 clk_sys = ~clk_sys;
   // Random wait states from the bus side
   always @(negedge clk_sys) begin
      sr <= nxt(sr);
      stall <= sr[0] & sr[3];
   end
   // Result watcher
   always @(negedge clk_sys) begin
      if (hostDone === 1'b1) begin
         chk("hostBusy", 32'h0, {31'h0, hostBusy});
         if (expQ.size() == 0) chk("expQ", 32'h1, 32'h0);
         else begin
            e = expQ.pop_front();
            if (e[32]) chk("hostRdata", e[31:0], hostRdata);
         end
      end
      if (htrans === TRANS_NSEQ) begin
         chk("hostBusy", 32'h1, {31'h0, hostBusy});
         if (curWr) chk("hwdata", ~lf, hwdata);
         chk("haddr", curAddr, haddr);
         chk("hsize", {29'h0, curSize}, {29'h0, hsize});
         chk("hwrite", {31'h0, curWr}, {31'h0, hwrite});
      end
   end
   initial begin
      #500_000;
      error_cnt++;
      report_and_stop;
   end
   initial begin
      repeat (4) @(negedge clk_sys);
      rst = 1'b0;
      for (int i = 0; i < 15; i++) begin
         lf = nxt(lf);
         curSize = 3'(i % 3);
         curWr = lf[7];
         curFail = lf[11];
         curAddr = (i < 3) ? (lf & ~32'h3) : lf;
         acc(SEL_ADDRESS, 1'b1, curAddr, 33'h0);
         acc(SEL_CONTROL, 1'b1, {29'h0, curSize}, 33'h0);
         acc(SEL_CONTROL, 1'b0, lf, {1'b1, 29'h0, curSize});
         acc(SEL_WINDOW, curWr, ~lf, {!curWr, ~curAddr});
         acc(SEL_CONTROL, 1'b0, lf, {1'b1, 28'h0, curFail, curSize});
         acc(SEL_ADDRESS, 1'b0, lf, {1'b1, curAddr});
      end
      acc(2'h3, 1'b0, lf, {1'b1, 32'h0});
      report_and_stop;
   end
endmodule // dbap_port_bench
